// [ppi_top.v]
// What this block does
// - eight sticky port 1 flags, each set by its input's request
// - five port 2 flags in bits 4..0; bits 7..5 read zero
// - eight sticky port 0 flags, each set by its input's request
// - control bit 5 enables port 2 inputs 4..0 requests
// - control bit 4 enables port 0 inputs 7..4 requests
// - control bit 3 enables port 0 inputs 3..0 requests
// - control bit 2 picks port 2 edge: 0 rising, 1 falling
// - control bit 1 picks port 1 edge: 0 rising, 1 falling
// - control bit 0 picks port 0 edge: 0 rising, 1 falling
// - control bit 6 sets pad drive: 0 minimum, 1 maximum
// - port 1 mask gives each pin its own interrupt enable
// - port 1 and port 2 flags reset to zero
`timescale 1ns/10ps
`default_nettype none
`include "ppi_defs.vh"

module ppi_top #(
   parameter AW = 12
) (
   input  wire                 pclk,
   input  wire                 presetn,
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [AW-1:0]        paddr,
   input  wire [31:0]          pwdata,
   input  wire [3:0]           pstrb,
   output reg  [31:0]          prdata,
   output reg                  pready,
   output reg                  pslverr,
   input  wire [`PPI_P0_W-1:0] port0_pins,
   input  wire [`PPI_P1_W-1:0] port1_pins,
   input  wire [`PPI_P2_W-1:0] port2_pins,
   output reg                  first_port_pending,
   output reg                  second_port_pending,
   output reg                  third_port_pending,
   output reg                  pad_drive_strength
);

   // flag state
   reg  [`PPI_P0_W-1:0] p0_flags_r;
   reg  [`PPI_P1_W-1:0] port1_pending_flags_r;
   reg  [`PPI_P2_W-1:0] port2_pending_flags_r;
   reg  [7:0]           port_irq_control_r;
   reg  [7:0]           port1_irq_mask_r;

   reg  [`PPI_P0_W-1:0] p0_flags_nxt;
   reg  [`PPI_P1_W-1:0] p1_flags_nxt;
   reg  [`PPI_P2_W-1:0] p2_flags_nxt;
   reg  [7:0]           p2_flags_full;
   reg  [7:0]           control_nxt;
   reg  [7:0]           mask_nxt;

   wire [`PPI_P0_W-1:0] p0_edge;
   wire [`PPI_P1_W-1:0] p1_edge;
   wire [`PPI_P2_W-1:0] p2_edge;

   // bus decode
   wire       setup_ph;
   wire       access_ph;
   wire       commit;
   wire       wr_commit;
   wire       lane0_wr;
   wire       aligned;
   wire [7:0] reg_idx;
   wire       hit_p0;
   wire       hit_p1;
   wire       hit_p2;
   wire       hit_ctl;
   wire       hit_msk;
   wire       mapped;
   wire [7:0] wbyte;

   reg        pready_nxt;
   reg        pslverr_nxt;
   reg [31:0] prdata_nxt;

   // enables
   wire [`PPI_P0_W-1:0] p0_enable;
   wire [`PPI_P1_W-1:0] p1_enable;
   wire [`PPI_P2_W-1:0] p2_enable;

   // index of a byte address, upper bits beyond 8 must be zero
   function [7:0] addr_to_idx;
      input [AW-1:0] a;
      reg   [AW-1:0] sh;
      begin
         sh          = a >> 2;
         addr_to_idx = sh[7:0];
      end
   endfunction

   // write-zero-to-clear with set winning over clear
   function [7:0] w0c_update;
      input [7:0] cur;
      input [7:0] set_ev;
      input       wr;
      input [7:0] data;
      reg   [7:0] kept;
      begin
         kept       = wr ? (cur & data) : cur;
         w0c_update = kept | set_ev;
      end
   endfunction

   // request flag of one port: any enabled and pending
   function any_enabled;
      input [7:0] flags;
      input [7:0] en;
      begin
         any_enabled = |(flags & en);
      end
   endfunction

   ppi_edge #(
      .W (`PPI_P0_W)
   ) u_edge_p0 (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_in     (port0_pins),
      .fall_sel   (port_irq_control_r[`PPI_CTL_P0_EDGE]),
      .edge_pulse (p0_edge)
   );

   ppi_edge #(
      .W (`PPI_P1_W)
   ) u_edge_p1 (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_in     (port1_pins),
      .fall_sel   (port_irq_control_r[`PPI_CTL_P1_EDGE]),
      .edge_pulse (p1_edge)
   );

   ppi_edge #(
      .W (`PPI_P2_W)
   ) u_edge_p2 (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin_in     (port2_pins),
      .fall_sel   (port_irq_control_r[`PPI_CTL_P2_EDGE]),
      .edge_pulse (p2_edge)
   );

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign commit    = access_ph & pready;
   assign wr_commit = commit & pwrite & ~pslverr;
   assign lane0_wr  = wr_commit & pstrb[0];
   assign aligned   = (paddr[1:0] == 2'b00);
   assign reg_idx   = addr_to_idx(paddr);
   assign wbyte     = pwdata[7:0];

   // address beyond the index byte is unmapped
   assign hit_p0  = aligned & ((paddr >> 10) == {AW{1'b0}})
                    & (reg_idx == `PPI_IDX_P0_FLAGS);
   assign hit_p1  = aligned & ((paddr >> 10) == {AW{1'b0}})
                    & (reg_idx == `PPI_IDX_P1_FLAGS);
   assign hit_p2  = aligned & ((paddr >> 10) == {AW{1'b0}})
                    & (reg_idx == `PPI_IDX_P2_FLAGS);
   assign hit_ctl = aligned & ((paddr >> 10) == {AW{1'b0}})
                    & (reg_idx == `PPI_IDX_CONTROL);
   assign hit_msk = aligned & ((paddr >> 10) == {AW{1'b0}})
                    & (reg_idx == `PPI_IDX_P1_MASK);
   assign mapped  = hit_p0 | hit_p1 | hit_p2 | hit_ctl | hit_msk;

   // group enables for ports 0 and 2, per pin for port 1
   assign p0_enable = {{4{port_irq_control_r[`PPI_CTL_P0_HI_EN]}},
                       {4{port_irq_control_r[`PPI_CTL_P0_LO_EN]}}};
   assign p1_enable = port1_irq_mask_r;
   assign p2_enable = {`PPI_P2_W{port_irq_control_r[`PPI_CTL_P2_EN]}};

   // one wait state: pready rises on the second access cycle
   always @* begin
      pready_nxt  = access_ph & ~pready;
      pslverr_nxt = access_ph & ~pready & ~mapped;
      prdata_nxt  = prdata;
      if (access_ph & ~pready) begin
         prdata_nxt = 32'h0000_0000;
         if (~pwrite) begin
            case (1'b1)
               hit_p0: begin
                  prdata_nxt[7:0] = p0_flags_r;
               end
               hit_p1: begin
                  prdata_nxt[7:0] = port1_pending_flags_r;
               end
               hit_p2: begin
                  prdata_nxt[7:0] = {3'b000, port2_pending_flags_r};
               end
               hit_ctl: begin
                  prdata_nxt[7:0] = port_irq_control_r;
               end
               hit_msk: begin
                  prdata_nxt[7:0] = port1_irq_mask_r;
               end
               default: begin
                  prdata_nxt = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // flag and register next values
   always @* begin
      p0_flags_nxt = w0c_update(p0_flags_r, p0_edge,
                                lane0_wr & hit_p0, wbyte);
      p1_flags_nxt = w0c_update(port1_pending_flags_r, p1_edge,
                                lane0_wr & hit_p1, wbyte);
      p2_flags_full = w0c_update({3'b000, port2_pending_flags_r},
                                 {3'b000, p2_edge},
                                 lane0_wr & hit_p2,
                                 wbyte & `PPI_P2_FLAG_MASK);
      p2_flags_nxt  = p2_flags_full[`PPI_P2_W-1:0];
      control_nxt  = port_irq_control_r;
      mask_nxt     = port1_irq_mask_r;
      if (lane0_wr & hit_ctl) begin
         control_nxt = wbyte & `PPI_CTL_WMASK;
      end
      if (lane0_wr & hit_msk) begin
         mask_nxt = wbyte;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p0_flags_r            <= `PPI_RST_FLAGS;
         port1_pending_flags_r <= `PPI_RST_FLAGS;
         port2_pending_flags_r <= 5'h00;
         port_irq_control_r    <= `PPI_RST_CONTROL;
         port1_irq_mask_r      <= `PPI_RST_MASK;
      end else begin
         p0_flags_r            <= p0_flags_nxt;
         port1_pending_flags_r <= p1_flags_nxt;
         port2_pending_flags_r <= p2_flags_nxt;
         port_irq_control_r    <= control_nxt;
         port1_irq_mask_r      <= mask_nxt;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= pready_nxt;
         pslverr <= pslverr_nxt;
         prdata  <= prdata_nxt;
      end
   end

   // requests follow the flag registers one cycle later
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_port_pending  <= 1'b0;
         second_port_pending <= 1'b0;
         third_port_pending  <= 1'b0;
         pad_drive_strength  <= 1'b0;
      end else begin
         first_port_pending  <= any_enabled(p0_flags_r, p0_enable);
         second_port_pending <= any_enabled(port1_pending_flags_r,
                                            p1_enable);
         third_port_pending  <= any_enabled({3'b000,
                                             port2_pending_flags_r},
                                            {3'b000, p2_enable});
         pad_drive_strength  <=
            port_irq_control_r[`PPI_CTL_PAD_DRIVE];
      end
   end

   // unused inputs besides lane 0 of pstrb
   wire unused_ok;
   assign unused_ok = &{1'b0, setup_ph, pstrb[3:1], pwdata[31:8]};

endmodule

`default_nettype wire

// [ppi_defs.vh]
`ifndef PPI_DEFS_VH
`define PPI_DEFS_VH

// register indices; byte address is four times the index
`define PPI_IDX_P0_FLAGS     8'h89
`define PPI_IDX_P1_FLAGS     8'h8a
`define PPI_IDX_P2_FLAGS     8'h8b
`define PPI_IDX_CONTROL      8'h8c
`define PPI_IDX_P1_MASK      8'h8d

// reset values
`define PPI_RST_FLAGS        8'h00
`define PPI_RST_CONTROL      8'h00
`define PPI_RST_MASK         8'h00

// port widths
`define PPI_P0_W             8
`define PPI_P1_W             8
`define PPI_P2_W             5

// control register fields
`define PPI_CTL_P0_EDGE      0
`define PPI_CTL_P1_EDGE      1
`define PPI_CTL_P2_EDGE      2
`define PPI_CTL_P0_LO_EN     3
`define PPI_CTL_P0_HI_EN     4
`define PPI_CTL_P2_EN        5
`define PPI_CTL_PAD_DRIVE    6
`define PPI_CTL_WMASK        8'h7f

// writable bits of the port 2 flag register
`define PPI_P2_FLAG_MASK     8'h1f

`endif

// [ppi_edge.v]
`timescale 1ns/10ps
`default_nettype none

// two-flop synchroniser plus one-cycle edge pulse, edge chosen by fall_sel
module ppi_edge #(
   parameter W = 8
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] pin_in,
   input  wire         fall_sel,
   output reg  [W-1:0] edge_pulse
);

   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;
   reg [W-1:0] prev_r;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r     <= {W{1'b0}};
         sync_r     <= {W{1'b0}};
         prev_r     <= {W{1'b0}};
         edge_pulse <= {W{1'b0}};
      end else begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
         if (fall_sel) begin
            edge_pulse <= prev_r & ~sync_r;
         end else begin
            edge_pulse <= sync_r & ~prev_r;
         end
      end
   end

endmodule

`default_nettype wire

// [ppi_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module ppi_asserts #(
   parameter AW = 12
) (
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [3:0]    pstrb,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          first_port_pending,
   input wire logic          second_port_pending,
   input wire logic          third_port_pending,
   input wire logic          pad_drive_strength
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [7:0] ctl_r;
   logic [7:0] msk_r;
   logic       wr_ok;
   logic       rd_ok;
   logic       ctl_wr;
   assign wr_ok = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
   assign rd_ok = pready && !pwrite && !pslverr;
   assign ctl_wr = wr_ok && paddr == 12'h230;
   // shadow copies of the control and mask registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= 8'h00;
         msk_r <= 8'h00;
      end else if (wr_ok && paddr == 12'h230) begin
         ctl_r <= pwdata[7:0] & 8'h7f;
      end else if (wr_ok && paddr == 12'h234) begin
         msk_r <= pwdata[7:0];
      end
   end
   a_p2_gate: assert property (!ctl_r[5] && !$past(ctl_r[5]) |-> !third_port_pending) else $error("port 2 request while disabled");
   a_p0_gate: assert property (ctl_r[4:3] == 2'b00 && $past(ctl_r[4:3]) == 2'b00 |-> !first_port_pending) else $error("port 0 request while disabled");
   a_p1_gate: assert property (msk_r == 8'h00 && $past(msk_r) == 8'h00 |-> !second_port_pending) else $error("port 1 request while masked");
   a_pad_write: assert property (ctl_wr |-> ##2 pad_drive_strength == $past(pwdata[6], 2)) else $error("pad drive not updated");
   a_pad_hold: assert property (!ctl_wr && !$past(ctl_wr) |=> $stable(pad_drive_strength)) else $error("pad drive moved");
   a_ctl_read: assert property (rd_ok && paddr == 12'h230 |-> prdata == {24'h000000, ctl_r}) else $error("control read wrong");
   a_mask_read: assert property (rd_ok && paddr == 12'h234 |-> prdata == {24'h000000, msk_r}) else $error("mask read wrong");
   a_p2_unused: assert property (rd_ok && paddr == 12'h22c |-> prdata[7:5] == 3'b000) else $error("port 2 unused bits set");
   a_pend_sticky: assert property (second_port_pending && !psel && !$past(psel) && !$past(psel, 2) |=> second_port_pending) else $error("request dropped");
   c_third: cover property (third_port_pending);
   c_clear: cover property (wr_ok && paddr == 12'h228);
   c_err: cover property (pready && pslverr);
endmodule
bind ppi_top ppi_asserts #(.AW(AW)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .first_port_pending, .second_port_pending, .third_port_pending, .pad_drive_strength);
`default_nettype wire

// [ppi_pin_src.sv]
`timescale 1ns/10ps
`default_nettype none
// drives the pins promptly (1 cycle) or slowly (3 cycles)
module ppi_pin_src (
   input wire logic        pclk,
   input wire logic        go,
   input wire logic        slow,
   input wire logic [20:0] want,
   output var logic [20:0] pins = 21'h0
);
   logic [20:0] hold_r = 21'h0;
   logic [1:0]  cnt_r = 2'h0;
   always @(posedge pclk) begin
      if (go) begin
         hold_r <= want;
         cnt_r <= slow ? 2'h3 : 2'h1;
      end else if (cnt_r != 2'h0) begin
         cnt_r <= cnt_r - 2'h1;
      end
      if (!go && cnt_r == 2'h1) pins <= hold_r;
   end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  msk;
      logic [20:0] pb;
      logic [20:0] pa;
      logic [20:0] fl;
      logic [2:0]  pd;
   } ppi_row_t;
   ppi_row_t rows [7] = '{
      '{8'h00, 8'h00, 21'h0, 21'h1fffff, 21'h1fffff, 3'b000},
      '{8'h3f, 8'h40, 21'h1fffff, 21'h0, 21'h1fffff, 3'b111},
      '{8'h08, 8'h00, 21'h0, 21'h00000f, 21'h00000f, 3'b001},
      '{8'h10, 8'h00, 21'h0, 21'h00000f, 21'h00000f, 3'b000},
      '{8'h00, 8'h00, 21'h1fffff, 21'h0, 21'h0, 3'b000},
      '{8'h20, 8'h00, 21'h0, 21'h010000, 21'h010000, 3'b100},
      '{8'h02, 8'h01, 21'h00ff00, 21'h00fd00, 21'h000200, 3'b000}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, slow;
   logic p0_req, p1_req, p2_req, pad, err_v;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [3:0]  pstrb;
   logic [20:0] want, pin_w;
   int miscompares = 0;
   int cmp_count = 0;
   ppi_top #(.AW(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port0_pins(pin_w[7:0]), .port1_pins(pin_w[15:8]),
      .port2_pins(pin_w[20:16]), .first_port_pending(p0_req),
      .second_port_pending(p1_req), .third_port_pending(p2_req),
      .pad_drive_strength(pad));
   ppi_pin_src u_src (.pclk(pclk), .go(go), .slow(slow), .want(want),
      .pins(pin_w));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pins(input logic [20:0] v, input logic s);
      @(posedge pclk);
      go <= 1'b1;
      want <= v;
      slow <= s;
      @(posedge pclk);
      go <= 1'b0;
      repeat (12) @(posedge pclk);
   endtask
   task automatic rst_chk;
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         apb(1'b0, 12'h224 + 12'(4 * a), 8'h00);
         chk(rd_v, 32'h0);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      #(40 * 8000);
      miscompares++;
      finish_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, go, slow} = 6'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      want = 21'h0;
      rst_chk;
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 12'h230, rows[i].ctl);
         apb(1'b1, 12'h234, rows[i].msk);
         pins(rows[i].pb, i[0]);
         for (int a = 0; a < 3; a++) apb(1'b1, 12'h224 + 12'(4 * a), 8'h00);
         pins(rows[i].pa, i[0]);
         apb(1'b0, 12'h224, 8'h00);
         chk(rd_v, {24'h0, rows[i].fl[7:0]});
         apb(1'b0, 12'h228, 8'h00);
         chk(rd_v, {24'h0, rows[i].fl[15:8]});
         apb(1'b0, 12'h22c, 8'h00);
         chk(rd_v, {27'h0, rows[i].fl[20:16]});
         chk({29'h0, p2_req, p1_req, p0_req}, {29'h0, rows[i].pd});
      end
      apb(1'b1, 12'h228, 8'hff);
      apb(1'b0, 12'h228, 8'h00);
      chk(rd_v, 32'h02);
      pins(21'h00fc00, 1'b0);
      apb(1'b1, 12'h228, 8'hfe);
      apb(1'b0, 12'h228, 8'h00);
      chk(rd_v, 32'h02);
      apb(1'b1, 12'h230, 8'hff);
      apb(1'b0, 12'h230, 8'h00);
      chk(rd_v, 32'h7f);
      chk({31'h0, pad}, 32'h1);
      pstrb <= 4'he;
      apb(1'b1, 12'h230, 8'h00);
      pstrb <= 4'hf;
      chk({31'h0, pad}, 32'h1);
      apb(1'b0, 12'h300, 8'h00);
      chk({31'h0, err_v}, 32'h1);
      pins(21'h0, 1'b1);
      rst_chk;
      chk({31'h0, pad}, 32'h0);
      finish_test;
   end
endmodule
`default_nettype wire
